// [rtl/led_mode_pkg.sv]
// Constants and helpers shared by the mode-control device and its host
// How it works
// - Bit 7 reads restart flag; write one clears
// - Host sets sleep before sleep plus external clock
// - External clock select sticky until software reset
// - Frame lasts 4096 times prescale plus one
// - Bit 5 advances pointer per access; resets clear
// - Bit 4 sleep stops oscillator; resets set
// - Oscillator runs within 500 us after wake
// - External clock needs no start-up delay
// - No PWM activity while oscillator stopped
// - Bit 0 enables broadcast address; resets set
// - Sleep with active channels sets flag at frame end
// - Channel registers kept intact during sleep
// - Write one to bit 7 restarts channels
// - Host waits 500 us awake before restart
// - Reset, stop or full channel write clears flag
// - Orderly shutdown before sleep clears flag
// - Host shuts down via off-high bit 4
// - Output change at stop or channel ack
// - Prescale writes ignored while awake
package led_mode_pkg;

  localparam int CLOCK_MHZ        = 10;
  localparam int OSC_START_US     = 500;
  localparam int OSC_START_CYCLES = OSC_START_US * CLOCK_MHZ;

  localparam logic [7:0] REG_PRIMARY_MODE   = 8'h00;
  localparam logic [7:0] REG_SECONDARY_MODE = 8'h01;
  localparam logic [7:0] CHAN_FIRST    = 8'h06;
  localparam logic [7:0] CHAN_LAST     = 8'h45;
  localparam logic [7:0] BCAST_FIRST   = 8'hFA;
  localparam logic [7:0] BCAST_LAST    = 8'hFD;
  localparam logic [7:0] REG_PRESCALE  = 8'hFE;

  localparam int CHANNELS   = 16;
  localparam int CHAN_BYTES = 64;
  localparam logic [1:0] BYTE_OFF_HIGH = 2'h3;
  localparam int OFF_FULL_BIT = 4;

  localparam int BIT_RESTART = 7;
  localparam int BIT_EXT_CLOCK = 6;
  localparam int BIT_AUTOINC = 5;
  localparam int BIT_SLEEP   = 4;
  localparam int BIT_SUB_ONE    = 3;
  localparam int BIT_SUB_TWO    = 2;
  localparam int BIT_SUB_THREE  = 1;
  localparam int BIT_BCAST      = 0;
  localparam int BIT_OUT_TIMING = 3;

  localparam logic [7:0] PRIMARY_MODE_RESET   = 8'h11;
  localparam logic [7:0] SECONDARY_MODE_RESET = 8'h04;
  localparam logic [7:0] SECONDARY_MODE_MASK  = 8'h1F;
  localparam logic [7:0] PRESCALE_RESET = 8'h03;
  localparam logic [11:0] FRAME_LAST    = 12'hFFF;

  localparam logic [7:0] HOST_CMD_ADDR    = 8'h00;
  localparam logic [7:0] HOST_STATUS_ADDR = 8'h04;
  localparam int CMD_WE    = 8;
  localparam int CMD_PTR   = 9;
  localparam int CMD_STOP  = 10;
  localparam int CMD_SWRST = 11;

  function automatic logic isChannelAddr(input logic [7:0] a);
    return (a >= CHAN_FIRST) && (a <= CHAN_LAST);
  endfunction : isChannelAddr

  function automatic logic isBroadcastAddr(input logic [7:0] a);
    return (a >= BCAST_FIRST) && (a <= BCAST_LAST);
  endfunction : isBroadcastAddr

  function automatic logic [7:0] nextPtr(input logic [7:0] a);
    if ((a == CHAN_LAST) || (a == REG_PRESCALE))
      return REG_PRIMARY_MODE;
    return 8'(a + 8'h01);
  endfunction : nextPtr

endpackage : led_mode_pkg

// [rtl/mode_link_if.sv]
// Register link between the mode-control host and device
`timescale 1ns/1ps
interface mode_link_if;
  logic       req;
  logic       ptrLoad;
  logic       we;
  logic [7:0] wdata;
  logic       stop;
  logic       swReset;
  logic       ack;
  logic [7:0] rdata;

  modport device (input req, input ptrLoad, input we, input wdata, input stop,
                  input swReset, output ack, output rdata);
  modport host (output req, output ptrLoad, output we, output wdata, output stop,
                output swReset, input ack, input rdata);
endinterface : mode_link_if

// [rtl/mode_control_device.sv]
// Mode register, restart logic, prescaler and frame counter of the LED controller
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module mode_control_device
  import led_mode_pkg::*;
#(
  parameter int OSC_START_CYC = OSC_START_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  mode_link_if.device      lnk,
  output logic [11:0]      pwmCount,
  output logic             frameTick,
  output logic             pwmRunning,
  output logic             extClockSelected,
  output logic             lowPower,
  output logic [2:0]       subAddressEnable,
  output logic             broadcastEnable,
  output logic             autoAdvance,
  output logic             restartChannels,
  output logic             outputUpdate
);

  typedef struct packed {
    logic [7:0]                      mode;
    logic [7:0]                      secondary_mode_control;
    logic [7:0]                      prescale;
    logic [7:0]                      ptr;
    logic [CHAN_BYTES-1:0][7:0]      pwm;
    logic [CHANNELS-1:0]             activeMask;
    logic [3:0]                      wrChan;
    logic [3:0]                      wrMask;
    logic                            pendWrite;
    logic                            sleepPending;
    logic [15:0]                     oscTimer;
    logic                            oscUp;
    logic [7:0]                      preCnt;
    logic [11:0]                     frameCnt;
    logic                            frameTick;
    logic                            ack;
    logic [7:0]                      rdata;
    logic                            restartPulse;
    logic                            updatePulse;
  } state_t;

  state_t     s_reg;
  state_t     s_next;
  logic [7:0] w;
  logic [5:0] idx;
  logic [1:0] byteSel;
  logic [3:0] chan;
  logic [3:0] mask;
  logic       run;
  logic [1:0] bcastByte;

  function automatic state_t resetState();
    state_t r;
    r          = '0;
    r.mode     = PRIMARY_MODE_RESET;
    r.secondary_mode_control    = SECONDARY_MODE_RESET;
    r.prescale = PRESCALE_RESET;
    return r;
  endfunction : resetState

  function automatic logic [7:0] readByte(input state_t st, input logic [7:0] a);
    logic [5:0] i;
    i = 6'(a - CHAN_FIRST);
    if (a == REG_PRIMARY_MODE)
      return st.mode;
    if (a == REG_SECONDARY_MODE)
      return st.secondary_mode_control;
    if (a == REG_PRESCALE)
      return st.prescale;
    if (isChannelAddr(a))
      return st.pwm[i];
    return 8'h00;
  endfunction : readByte

  always_comb begin
    s_next              = s_reg;
    s_next.ack          = 1'b0;
    s_next.frameTick    = 1'b0;
    s_next.restartPulse = 1'b0;
    s_next.updatePulse  = 1'b0;
    w       = lnk.wdata;
    idx     = 6'(s_reg.ptr - CHAN_FIRST);
    byteSel = idx[1:0];
    chan    = idx[5:2];
    mask    = 4'h0;
    run     = 1'b0;
    bcastByte = 2'(s_reg.ptr - BCAST_FIRST);

    // Register access, one per request
    if (lnk.req && !s_reg.ack) begin
      s_next.ack = 1'b1;
      if (lnk.ptrLoad) begin
        s_next.ptr = w;
      end else begin
        if (!lnk.we) begin
          s_next.rdata = readByte(s_reg, s_reg.ptr);
        end else if (s_reg.ptr == REG_PRIMARY_MODE) begin
          s_next.mode[BIT_AUTOINC]   = w[BIT_AUTOINC];
          s_next.mode[BIT_SLEEP]     = w[BIT_SLEEP];
          s_next.mode[BIT_SUB_ONE]   = w[BIT_SUB_ONE];
          s_next.mode[BIT_SUB_TWO]   = w[BIT_SUB_TWO];
          s_next.mode[BIT_SUB_THREE] = w[BIT_SUB_THREE];
          s_next.mode[BIT_BCAST]     = w[BIT_BCAST];
          if (w[BIT_EXT_CLOCK] && w[BIT_SLEEP] && s_reg.mode[BIT_SLEEP])
            s_next.mode[BIT_EXT_CLOCK] = 1'b1;
          if (w[BIT_RESTART]) begin
            s_next.mode[BIT_RESTART] = 1'b0;
            if (s_reg.mode[BIT_RESTART] && !s_reg.mode[BIT_SLEEP] && !w[BIT_SLEEP])
              s_next.restartPulse = 1'b1;
          end
          if (!w[BIT_SLEEP])
            s_next.sleepPending = 1'b0;
          else if (!s_reg.mode[BIT_SLEEP]) begin
            if (s_reg.activeMask != '0)
              s_next.sleepPending = 1'b1;
            else
              s_next.mode[BIT_RESTART] = 1'b0;
          end
        end else if (s_reg.ptr == REG_SECONDARY_MODE) begin
          s_next.secondary_mode_control = w & SECONDARY_MODE_MASK;
        end else if (s_reg.ptr == REG_PRESCALE) begin
          if (s_reg.mode[BIT_SLEEP])
            s_next.prescale = w;
        end else if (isChannelAddr(s_reg.ptr)) begin
          s_next.pwm[idx]  = w;
          s_next.pendWrite = 1'b1;
          if (byteSel == BYTE_OFF_HIGH)
            s_next.activeMask[chan] = !w[OFF_FULL_BIT];
          mask = (chan == s_reg.wrChan) ? s_reg.wrMask : 4'h0;
          mask[byteSel] = 1'b1;
          s_next.wrChan = chan;
          s_next.wrMask = mask;
          if (mask == 4'hF) begin
            s_next.wrMask = 4'h0;
            if (s_reg.secondary_mode_control[BIT_OUT_TIMING]) begin
              s_next.mode[BIT_RESTART] = 1'b0;
              s_next.updatePulse       = 1'b1;
            end
          end
        end else if (isBroadcastAddr(s_reg.ptr)) begin
          s_next.pendWrite = 1'b1;
          for (int i = 0; i < CHANNELS; i++) begin
            s_next.pwm[i*(CHAN_BYTES/CHANNELS) + int'(bcastByte)] = w;
          end
          if (s_reg.ptr == BCAST_LAST)
            s_next.activeMask = w[OFF_FULL_BIT] ? '0 : '1;
        end
        if (s_reg.mode[BIT_AUTOINC])
          s_next.ptr = nextPtr(s_reg.ptr);
      end
    end

    // Stop ends a write burst
    if (lnk.stop) begin
      s_next.pendWrite = 1'b0;
      if (s_reg.pendWrite && !s_reg.secondary_mode_control[BIT_OUT_TIMING]) begin
        s_next.mode[BIT_RESTART] = 1'b0;
        s_next.updatePulse       = 1'b1;
      end
    end

    // Oscillator start-up, kept alive until a pending frame ends
    if (s_reg.mode[BIT_SLEEP] && !s_reg.sleepPending) begin
      s_next.oscUp    = 1'b0;
      s_next.oscTimer = '0;
    end else if (!s_reg.oscUp) begin
      if (s_reg.mode[BIT_EXT_CLOCK])
        s_next.oscUp = 1'b1;
      else if (s_reg.oscTimer == 16'(OSC_START_CYC - 1))
        s_next.oscUp = 1'b1;
      else
        s_next.oscTimer = 16'(s_reg.oscTimer + 16'h0001);
    end

    // Frame counter, halted while the clock is off
    run = s_reg.oscUp && (!s_reg.mode[BIT_SLEEP] || s_reg.sleepPending);
    if (run) begin
      if (s_reg.preCnt == s_reg.prescale) begin
        s_next.preCnt   = 8'h00;
        s_next.frameCnt = 12'(s_reg.frameCnt + 12'h001);
        if (s_reg.frameCnt == FRAME_LAST) begin
          s_next.frameTick = 1'b1;
          if (s_reg.sleepPending) begin
            s_next.sleepPending      = 1'b0;
            s_next.mode[BIT_RESTART] = 1'b1;
          end
        end
      end else begin
        s_next.preCnt = 8'(s_reg.preCnt + 8'h01);
      end
    end
    if (s_next.restartPulse) begin
      s_next.preCnt   = 8'h00;
      s_next.frameCnt = 12'h000;
    end

    if (lnk.swReset)
      s_next = resetState();
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      s_reg <= resetState();
    else
      s_reg <= s_next;
  end

  assign lnk.ack          = s_reg.ack;
  assign lnk.rdata        = s_reg.rdata;
  assign pwmCount         = s_reg.frameCnt;
  assign frameTick        = s_reg.frameTick;
  assign pwmRunning       = s_reg.oscUp;
  assign extClockSelected = s_reg.mode[BIT_EXT_CLOCK];
  assign lowPower         = s_reg.mode[BIT_SLEEP];
  assign subAddressEnable = s_reg.mode[BIT_SUB_ONE:BIT_SUB_THREE];
  assign broadcastEnable  = s_reg.mode[BIT_BCAST];
  assign autoAdvance      = s_reg.mode[BIT_AUTOINC];
  assign restartChannels  = s_reg.restartPulse;
  assign outputUpdate     = s_reg.updatePulse;

endmodule : mode_control_device

// [rtl/mode_control_host.sv]
// Wishbone-commanded host that drives the mode-control register link
`timescale 1ns/1ps
module mode_control_host
  import led_mode_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  mode_link_if.host        lnk,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);

  typedef struct packed {
    logic        req;
    logic        ptrLoad;
    logic        we;
    logic [7:0]  wdata;
    logic        stop;
    logic        swReset;
    logic        busy;
    logic [7:0]  rdata;
    logic        wbAck;
    logic [31:0] wbDat;
  } host_state_t;

  host_state_t s_reg;
  host_state_t s_next;

  always_comb begin
    s_next         = s_reg;
    s_next.wbAck   = 1'b0;
    s_next.stop    = 1'b0;
    s_next.swReset = 1'b0;
    // Request held until the device answers
    if (s_reg.req && lnk.ack) begin
      s_next.req   = 1'b0;
      s_next.busy  = 1'b0;
      s_next.rdata = lnk.rdata;
    end
    if (cyc_i && stb_i && !s_reg.wbAck) begin
      s_next.wbAck = 1'b1;
      s_next.wbDat = 32'h0000_0000;
      if (adr_i == HOST_CMD_ADDR) begin
        if (we_i && sel_i[0] && sel_i[1] && !s_reg.busy) begin
          if (dat_i[CMD_STOP])
            s_next.stop = 1'b1;
          else if (dat_i[CMD_SWRST])
            s_next.swReset = 1'b1;
          else begin
            s_next.req     = 1'b1;
            s_next.busy    = 1'b1;
            s_next.we      = dat_i[CMD_WE];
            s_next.ptrLoad = dat_i[CMD_PTR];
            s_next.wdata   = dat_i[7:0];
          end
        end
      end else if (adr_i == HOST_STATUS_ADDR && !we_i) begin
        s_next.wbDat = {16'h0000, s_reg.rdata, 7'h00, s_reg.busy};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign lnk.req     = s_reg.req;
  assign lnk.ptrLoad = s_reg.ptrLoad;
  assign lnk.we      = s_reg.we;
  assign lnk.wdata   = s_reg.wdata;
  assign lnk.stop    = s_reg.stop;
  assign lnk.swReset = s_reg.swReset;
  assign dat_o       = s_reg.wbDat;
  assign ack_o       = s_reg.wbAck;

endmodule : mode_control_host

// [tb/mode_link_checker.sv]
// Assertions on the host-device link and the device status outputs
`timescale 1ns/1ps
module mode_link_checker #(
  parameter int OSC_START_CYC = 20
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       req,
  input wire logic       stop,
  input wire logic       swReset,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       pwmRunning,
  input wire logic       frameTick,
  input wire logic       extClockSelected,
  input wire logic       lowPower,
  input wire logic       broadcastEnable,
  input wire logic       autoAdvance,
  input wire logic       restartChannels,
  input wire logic       outputUpdate
);
  localparam int WAKE_MAX = OSC_START_CYC + 2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_wake;
    $fell(lowPower);
  endsequence
  sequence s_ext_wake;
    extClockSelected ##0 s_wake;
  endsequence
  a_ack_after_req: assert property (req && !ack |=> ack)
    else $error("link request not answered next cycle");
  a_ack_single: assert property (ack |=> !ack)
    else $error("link answer longer than one cycle");
  a_rdata_on_ack: assert property ($changed(rdata) |-> ack || $past(swReset))
    else $error("read data changed without an answer");
  a_no_tick_asleep: assert property (frameTick |-> $past(pwmRunning))
    else $error("frame wrapped with oscillator stopped");
  a_ext_no_delay: assert property (s_ext_wake |-> ##[0:2] pwmRunning)
    else $error("external clock wake delayed");
  a_osc_wake_bound: assert property (s_wake |-> ##[0:WAKE_MAX] pwmRunning)
    else $error("oscillator late after wake");
  a_ext_sticky: assert property (extClockSelected && !swReset |=> extClockSelected)
    else $error("external clock select dropped");
  a_swreset_defaults: assert property (swReset |=> lowPower && broadcastEnable
    && !autoAdvance && !extClockSelected) else $error("software reset defaults wrong");
  a_restart_awake: assert property (restartChannels |-> !lowPower)
    else $error("restart while asleep");
  a_update_cause: assert property (outputUpdate |-> ack || $past(ack)
    || $past(ack, 2) || $past(stop) || $past(stop, 2)) else $error("update without cause");
endmodule : mode_link_checker

// [tb/tb.sv]
// Bench for the mode-control host and device pair
`timescale 1ns/1ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin nErrors++; \
  $display("unexpected %0t: got %0h want %0h", $time, a, e); end end
module tb;
  import led_mode_pkg::*;
  localparam int OSC = 20;
  logic        clock, rst_n, cyc, stb, we, ackO;
  logic        pwmRunning, frameTick, external_clock_pin_select, lowPower, bcast, autoAdv, restart, update;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [11:0] pwmCnt;
  logic [2:0]  subEn;
  logic [31:0] dat, datO;
  int          nErrors, nCompared, nRestart, nUpdate;
  mode_link_if lnk ();
  mode_control_host mode_control_host_i (.clock(clock), .rst_n(rst_n), .lnk(lnk), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ackO));
  mode_control_device #(.OSC_START_CYC(OSC)) mode_control_device_i (.clock(clock),
    .rst_n(rst_n), .lnk(lnk), .pwmCount(pwmCnt), .frameTick(frameTick), .pwmRunning(pwmRunning),
    .extClockSelected(external_clock_pin_select), .lowPower(lowPower), .subAddressEnable(subEn),
    .broadcastEnable(bcast), .autoAdvance(autoAdv), .restartChannels(restart),
    .outputUpdate(update));
  mode_link_checker #(.OSC_START_CYC(OSC)) chk_i (.clock(clock), .rst_n(rst_n),
    .req(lnk.req), .stop(lnk.stop), .swReset(lnk.swReset), .ack(lnk.ack), .rdata(lnk.rdata),
    .pwmRunning(pwmRunning), .frameTick(frameTick), .extClockSelected(external_clock_pin_select),
    .lowPower(lowPower), .broadcastEnable(bcast), .autoAdvance(autoAdv),
    .restartChannels(restart), .outputUpdate(update));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (restart === 1'b1) nRestart <= nRestart + 1;
    if (update === 1'b1) nUpdate <= nUpdate + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do @(posedge clock); while (ackO !== 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic cmd(input logic [11:0] c);
    logic [31:0] q;
    wb(1'b1, HOST_CMD_ADDR, {20'h0, c}, q);
    q = 32'h1;
    for (int i = 0; i < 50 && q[0] !== 1'b0; i++) wb(1'b0, HOST_STATUS_ADDR, 32'h0, q);
    if (q[0] !== 1'b0) begin
      nErrors++;
      $display("unexpected %0t: host stayed busy", $time);
    end
  endtask : cmd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd({4'h2, a});
    cmd({4'h1, d});
  endtask : wr
  task automatic rdHere(output logic [7:0] v);
    logic [31:0] q;
    cmd(12'h000);
    wb(1'b0, HOST_STATUS_ADDR, 32'h0, q);
    v = q[15:8];
  endtask : rdHere
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cmd({4'h2, a});
    rdHere(v);
    `CHK(v, e)
  endtask : rdChk
  task automatic waitTick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (frameTick !== 1'b1 && n < 20000);
    if (frameTick !== 1'b1) begin
      nErrors++;
      $display("unexpected %0t: no frame wrap", $time);
    end
  endtask : waitTick
  task automatic sleepActive;
    int n;
    wr(REG_PRIMARY_MODE, 8'h01);
    tick(OSC + 5);
    wr(REG_PRIMARY_MODE, 8'h11);
    waitTick(n);
    tick(3);
    rdChk(REG_PRIMARY_MODE, 8'h91);
  endtask : sleepActive
  task automatic testReset;
    logic [31:0] q;
    rdChk(REG_PRIMARY_MODE, PRIMARY_MODE_RESET);
    `CHK(lowPower, 1'b1)
    `CHK(bcast, 1'b1)
    `CHK(subEn, 3'b000)
    `CHK(autoAdv, 1'b0)
    wb(1'b0, 8'h08, 32'h0, q);
    `CHK(q, 32'h0)
    $display("reset test done");
  endtask : testReset
  task automatic testBits;
    logic [7:0] v;
    wr(REG_PRESCALE, 8'h00);
    rdChk(REG_PRESCALE, 8'h00);
    wr(REG_PRIMARY_MODE, 8'h2E);
    `CHK(subEn, 3'b111)
    `CHK(bcast, 1'b0)
    `CHK(autoAdv, 1'b1)
    `CHK(lowPower, 1'b0)
    wr(REG_PRESCALE, 8'h55);
    rdChk(REG_PRESCALE, 8'h00);
    cmd(12'h200);
    rdHere(v);
    rdHere(v);
    `CHK(v, SECONDARY_MODE_RESET)
    wr(REG_PRIMARY_MODE, 8'h01);
    $display("mode bits test done");
  endtask : testBits
  task automatic testExtClk;
    wr(REG_PRIMARY_MODE, 8'h41);
    `CHK(external_clock_pin_select, 1'b0)
    wr(REG_PRIMARY_MODE, 8'h11);
    wr(REG_PRIMARY_MODE, 8'h51);
    `CHK(external_clock_pin_select, 1'b1)
    wr(REG_PRIMARY_MODE, 8'h01);
    `CHK(external_clock_pin_select, 1'b1)
    `CHK(pwmRunning, 1'b1)
    cmd(12'h800);
    `CHK(external_clock_pin_select, 1'b0)
    rdChk(REG_PRIMARY_MODE, PRIMARY_MODE_RESET);
    $display("external clock test done");
  endtask : testExtClk
  task automatic testRestart;
    int n;
    wr(REG_PRESCALE, 8'h00);
    wr(8'h08, 8'hA5);
    wr(8'h09, 8'h00);
    sleepActive;
    rdChk(8'h08, 8'hA5);
    wr(REG_PRIMARY_MODE, 8'h01);
    rdChk(REG_PRIMARY_MODE, 8'h81);
    tick(OSC + 5);
    n = nRestart;
    wr(REG_PRIMARY_MODE, 8'h81);
    `CHK(nRestart, n + 1)
    rdChk(REG_PRIMARY_MODE, 8'h01);
    waitTick(n);
    waitTick(n);
    `CHK(n, 4096)
    `CHK(pwmCnt, 12'h000)
    $display("restart test done");
  endtask : testRestart
  task automatic testClear;
    int n;
    sleepActive;
    n = nUpdate;
    wr(8'h06, 8'h12);
    cmd(12'h400);
    `CHK(nUpdate, n + 1)
    rdChk(REG_PRIMARY_MODE, 8'h11);
    wr(REG_SECONDARY_MODE, 8'h0C);
    sleepActive;
    wr(REG_PRIMARY_MODE, 8'h31);
    n = nUpdate;
    cmd(12'h20A);
    repeat (4) cmd(12'h100);
    `CHK(nUpdate, n + 1)
    rdChk(REG_PRIMARY_MODE, 8'h31);
    wr(REG_SECONDARY_MODE, 8'h04);
    sleepActive;
    wr(REG_PRIMARY_MODE, 8'h01);
    wr(BCAST_LAST, 8'h10);
    wr(REG_PRIMARY_MODE, 8'h11);
    rdChk(REG_PRIMARY_MODE, 8'h11);
    rdChk(BCAST_LAST, 8'h00);
    $display("flag clearing test done");
  endtask : testClear
  task automatic conclude;
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) @(posedge clock);
    nErrors++;
    conclude;
  end
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, adr, dat, sel} = '0;
    {nErrors, nCompared, nRestart, nUpdate} = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    testReset;
    testBits;
    testExtClk;
    testRestart;
    testClear;
    conclude;
  end
endmodule : tb
